// [test/efc_peer_model.sv]
// remote serial peer: drives the receive stream and clear-to-send pin
// assumes the bench calls its tasks from the pclk domain
`timescale 1ns/1ps
module efc_peer_model (
  // clock
  input  wire logic pclk,
  // modem pin
  output logic      cts_in,
  // receive stream
  output logic       rx_valid,
  output logic [7:0] rx_char
);
  // ------------------------------------------------------------
  // line state
  // ------------------------------------------------------------
  // idle values at time zero, peer starts clear to send
  initial
  begin
    cts_in   = 1'h0;
    rx_valid = 1'h0;
    rx_char  = 8'h00;
  end

  // ------------------------------------------------------------
  // stimulus tasks
  // ------------------------------------------------------------
  // pause/resume as control
  // one char per call; idle data is inverted so a stale copy never matches
  task send_char(input logic [7:0] c);
    @(posedge pclk);
    rx_valid <= 1'h1;
    rx_char  <= c;
    @(posedge pclk);
    rx_valid <= 1'h0;
    rx_char  <= ~c;
  endtask : send_char

  // peer not clear
  // level held until the next call
  task set_cts(input logic v);
    @(posedge pclk);
    cts_in <= v;
  endtask : set_cts
endmodule : efc_peer_model

// [test/uart_enhanced_flow_control_tb.sv]
// bench for the enhanced flow-control block: apb tasks plus peer stream
// assumes the peer model drives cts and the receive characters
`timescale 1ns/1ps
module uart_enhanced_flow_control_tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cts_in;
  logic        rts_out;
  logic        rx_valid;
  logic [7:0]  rx_char;
  logic [5:0]  rx_fill;
  logic        rx_push;
  logic [7:0]  rx_push_data;
  logic        rx_irq;
  logic        tx_want;
  logic        tx_start_ok;
  logic        send_pause;
  logic        send_resume;
  logic [1:0]  send_select;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch;
  int          compares;
  int          n_pause;
  int          n_resume;

  // 100 MHz clock
  initial pclk = 1'h0;
  always #5 pclk = ~pclk;

  // count one-cycle transmitter requests as they stand at each edge
  always @(posedge pclk)
  begin
    if (send_pause === 1'h1)
      n_pause++;
    if (send_resume === 1'h1)
      n_resume++;
  end

  efc_ctrl u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cts_in(cts_in),
    .rts_out(rts_out), .rx_valid(rx_valid), .rx_char(rx_char),
    .rx_fill(rx_fill), .rx_push(rx_push), .rx_push_data(rx_push_data),
    .rx_irq(rx_irq), .tx_want(tx_want), .tx_start_ok(tx_start_ok),
    .send_pause(send_pause), .send_resume(send_resume),
    .send_select(send_select)
  );

  efc_peer_model u_peer (
    .pclk(pclk), .cts_in(cts_in), .rx_valid(rx_valid), .rx_char(rx_char)
  );

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task chk(input string w, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task pin(input string w, input logic e, input logic g);
    chk(w, {31'h0, e}, {31'h0, g});
  endtask : pin

  // request held until pready is seen high, released only after it
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task rdc(input logic [7:0] a, input logic [31:0] e, input string w);
    apb(1'h0, a, 32'h0);
    chk(w, e, rd);
  endtask : rdc

  // settle past the edge so registered outputs have landed
  task cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : cyc

  task fill(input logic [5:0] f);
    @(posedge pclk);
    rx_fill <= f;
    cyc(3);
  endtask : fill

  task rx(input logic [7:0] c, input logic pushed);
    u_peer.send_char(c);
    #1;
    pin("rx_push", pushed, rx_push);
  endtask : rx

  task end_sim;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  // watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge pclk);
    $display("watchdog expired");
    n_mismatch++;
    end_sim;
  end

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    presetn = 1'h0;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    rx_fill = 6'h00;
    tx_want = 1'h1;
    n_mismatch = 0;
    compares   = 0;
    repeat (10) @(posedge pclk);
    #1;
    pin("rts in reset", 1'h1, rts_out);
    @(posedge pclk);
    presetn <= 1'h1;
    rdc(efc_pkg::ADDR_EFC, 32'h0, "feature reset");
    rdc(efc_pkg::ADDR_ISR, 32'h1, "isr reset");
    pin("legacy rts", 1'h1, rts_out);
    apb(1'h1, efc_pkg::ADDR_MCR, 32'h2);
    cyc(2);
    pin("legacy rts set", 1'h0, rts_out);
    apb(1'h0, 8'h30, 32'h0);
    pin("unmapped err", 1'h1, err);
    $display("test reset and legacy done");

    // gate: save on clear, block while clear, restore on set
    apb(1'h1, efc_pkg::ADDR_EFC, 32'h10);
    apb(1'h1, efc_pkg::ADDR_IER, 32'hF5);
    rdc(efc_pkg::ADDR_IER, 32'hF5, "ier gate on");
    apb(1'h1, efc_pkg::ADDR_EFC, 32'h00);
    rdc(efc_pkg::ADDR_IER, 32'h05, "ier gate off");
    apb(1'h1, efc_pkg::ADDR_IER, 32'hA6);
    rdc(efc_pkg::ADDR_IER, 32'h06, "ier locked");
    apb(1'h1, efc_pkg::ADDR_EFC, 32'h10);
    rdc(efc_pkg::ADDR_IER, 32'hF6, "ier restored");
    $display("test gate done");

    // auto cts
    apb(1'h1, efc_pkg::ADDR_EFC, 32'h90);
    u_peer.set_cts(1'h1);
    cyc(2);
    pin("tx ok cts high", 1'h0, tx_start_ok);
    u_peer.set_cts(1'h0);
    cyc(2);
    pin("tx ok cts low", 1'h1, tx_start_ok);
    $display("test cts done");

    // auto rts; fill above the level first with the feature off
    apb(1'h1, efc_pkg::ADDR_EFC, 32'h10);
    fill(6'h0C);
    pin("rts auto off", 1'h0, rts_out);
    // drop below next level before enabling, else the stale fill raises rts
    fill(6'h0B);
    // transmit pair 10 selected so rts edges ask for pause and resume
    apb(1'h1, efc_pkg::ADDR_EFC, 32'h58);
    cyc(3);
    pin("rts below next", 1'h0, rts_out);
    pin("irq at level", 1'h1, rx_irq);
    fill(6'h0C);
    pin("rts next level", 1'h1, rts_out);
    chk("pause pulses", 32'h1, 32'(n_pause));
    rdc(efc_pkg::ADDR_EFC, 32'h58, "rts bit held");
    fill(6'h08);
    pin("rts at level", 1'h1, rts_out);
    fill(6'h07);
    pin("rts drained", 1'h0, rts_out);
    pin("irq drained", 1'h0, rx_irq);
    chk("resume pulses", 32'h1, 32'(n_resume));
    rdc(efc_pkg::ADDR_EFC, 32'h18, "rts bit free");
    fill(6'h00);
    $display("test rts done");

    // special char; select bits cleared first by software
    apb(1'h1, efc_pkg::ADDR_EFC, 32'h30);
    apb(1'h1, efc_pkg::ADDR_PAU2, 32'h13);
    rx(8'h12, 1'h1);
    rdc(efc_pkg::ADDR_ISR, 32'h01, "isr lsb differs");
    rx(8'h13, 1'h1);
    chk("push data", 32'h13, {24'h0, rx_push_data});
    rdc(efc_pkg::ADDR_ISR, 32'h11, "isr special");
    rdc(efc_pkg::ADDR_ISR, 32'h01, "isr cleared");
    $display("test special done");

    // in-band flow control, first pair
    apb(1'h1, efc_pkg::ADDR_EFC, 32'h0A);
    apb(1'h1, efc_pkg::ADDR_RES1, 32'h11);
    apb(1'h1, efc_pkg::ADDR_PAU1, 32'h13);
    rx(8'h13, 1'h0);
    cyc(1);
    pin("halt pair1", 1'h0, tx_start_ok);
    rdc(efc_pkg::ADDR_STAT, 32'h1, "status halted");
    rx(8'h41, 1'h1);
    rx(8'h11, 1'h0);
    cyc(1);
    pin("resume pair1", 1'h1, tx_start_ok);
    // second pair only; first pair chars are plain data here
    apb(1'h1, efc_pkg::ADDR_EFC, 32'h05);
    apb(1'h1, efc_pkg::ADDR_RES2, 32'h21);
    apb(1'h1, efc_pkg::ADDR_PAU2, 32'h23);
    rx(8'h13, 1'h1);
    rx(8'h23, 1'h0);
    cyc(1);
    pin("halt pair2", 1'h0, tx_start_ok);
    rx(8'h21, 1'h0);
    cyc(1);
    pin("resume pair2", 1'h1, tx_start_ok);
    // two-char sequences
    apb(1'h1, efc_pkg::ADDR_EFC, 32'h0F);
    rx(8'h13, 1'h0);
    rx(8'h23, 1'h0);
    cyc(1);
    pin("halt sequence", 1'h0, tx_start_ok);
    rx(8'h11, 1'h0);
    rx(8'h21, 1'h0);
    cyc(1);
    pin("resume sequence", 1'h1, tx_start_ok);
    $display("test inband done");

    // every transmit select code reaches the transmitter
    for (int i = 0; i < 4; i++)
    begin
      apb(1'h1, efc_pkg::ADDR_EFC, 32'(i) << 2);
      cyc(1);
      chk("send_select", 32'(i), {30'h0, send_select});
    end
    $display("test select done");
    end_sim;
  end
endmodule : uart_enhanced_flow_control_tb

// [verilog/efc_ctrl.sv]
// enhanced flow control for one serial channel, APB slave
// assumes the transmitter, receiver and fifos sit outside this block
//
// Function
// - auto-cts on: no new transmit character starts while cts input is 1
// - auto-cts on: transmission resumes once cts input returns to 0
// - auto-rts on: receive interrupt when rx fill reaches trigger level
// - auto-rts on: rts goes 1 when fill reaches next level above trigger
// - rts returns to 0 once fill drops below programmed trigger level
// - hardware flow off: rts follows software modem control bit only
// - readable auto-rts bit tracks current hardware flow control status
// - special detect on: each received char compared with second pause char
// - special match: char enters fifo unless it is an active on/off char, isr special flag is set while gate is 1
// - bit zero of each char register matches received char lsb
// - ier, isr, fcr, mcr enhanced fields writable only while gate is 1; isr has no apb write path here, so its fields are never writable
// - clearing gate saves enhanced fields then forces them to zero
// - setting gate unlocks enhanced field writes and restores saved fields
// - tx select: 00 none, 10 first pair, 01 second pair, 11 both
// - rx select: 00 none, 10 first pair, 01 second pair
// - rx select 11 matches two-character on and off sequences
// - paired modes 10 and 01 use one char register as on char, the other as off char
// - active on/off characters are control only, never payload
// - enhanced_feature_control resets to all zero
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
module efc_ctrl #(
  parameter int FILL_W = 6
) (
  // apb
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // modem pins
  input  wire logic              cts_in,
  output logic                   rts_out,
  // receive side
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_char,
  input  wire logic [FILL_W-1:0] rx_fill,
  output logic                   rx_push,
  output logic      [7:0]        rx_push_data,
  output logic                   rx_irq,
  // transmit side
  input  wire logic              tx_want,
  output logic                   tx_start_ok,
  output logic                   send_pause,
  output logic                   send_resume,
  output logic      [1:0]        send_select
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0]        efc_reg;
  logic [7:0]        res1_reg, res2_reg, pau1_reg, pau2_reg;
  logic [7:0]        ier_reg, isr_reg, fcr_reg, mcr_reg;
  logic [7:0]        sav_ier_reg, sav_isr_reg, sav_fcr_reg, sav_mcr_reg;
  logic [5:0]        trig_reg;
  logic              rts_hold_reg;
  logic              halted_reg;
  logic              on_half_reg, off_half_reg;
  logic              prev_full_reg;
  logic              wr, rd;
  logic              hit_addr;
  logic              gate;
  logic [7:0]        wbyte;
  logic [FILL_W-1:0] trig_lvl, next_lvl;
  logic [1:0]        rx_sel, tx_sel;
  logic              sw_flow;
  logic              on_hit, off_hit;
  logic              on_first, off_first;
  logic              spec_hit;

  assign wr     = psel & penable & pwrite;
  assign rd     = psel & penable & ~pwrite;
  assign wbyte  = pwdata[7:0];
  assign gate   = efc_reg[efc_pkg::EFC_GATE];
  assign rx_sel = efc_reg[efc_pkg::EFC_RX_HI:efc_pkg::EFC_RX_LO];
  assign tx_sel = efc_reg[efc_pkg::EFC_TX_HI:efc_pkg::EFC_TX_LO];
  assign sw_flow = (rx_sel != 2'b00);
  assign pready = 1'b1; // zero wait states
  assign trig_lvl = FILL_W'(trig_reg);
  assign next_lvl = FILL_W'(trig_reg) + FILL_W'(efc_pkg::TRIG_STEP);

  // address decode, unmapped answers pslverr
  always_comb
  begin
    case (paddr)
      efc_pkg::ADDR_EFC, efc_pkg::ADDR_RES1, efc_pkg::ADDR_RES2,
      efc_pkg::ADDR_PAU1, efc_pkg::ADDR_PAU2, efc_pkg::ADDR_IER,
      efc_pkg::ADDR_ISR, efc_pkg::ADDR_FCR, efc_pkg::ADDR_MCR,
      efc_pkg::ADDR_STAT, efc_pkg::ADDR_TRIG: hit_addr = 1'b1;
      default: hit_addr = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~hit_addr;

  // ------------------------------------------------------------
  // feature register and character registers
  // ------------------------------------------------------------
  // zero at reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      efc_reg <= efc_pkg::RST_EFC;
    else if (wr && paddr == efc_pkg::ADDR_EFC)
      efc_reg <= wbyte;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      res1_reg <= efc_pkg::RST_ZERO;
      res2_reg <= efc_pkg::RST_ZERO;
      pau1_reg <= efc_pkg::RST_ZERO;
      pau2_reg <= efc_pkg::RST_ZERO;
      trig_reg <= efc_pkg::RST_TRIG;
    end
    else if (wr)
    begin
      if (paddr == efc_pkg::ADDR_RES1) res1_reg <= wbyte;
      if (paddr == efc_pkg::ADDR_RES2) res2_reg <= wbyte;
      if (paddr == efc_pkg::ADDR_PAU1) pau1_reg <= wbyte;
      if (paddr == efc_pkg::ADDR_PAU2) pau2_reg <= wbyte;
      if (paddr == efc_pkg::ADDR_TRIG) trig_reg <= pwdata[5:0];
    end
  end

  // ------------------------------------------------------------
  // gated enhanced fields with save and restore
  // ------------------------------------------------------------
  // a write to the gate and a legacy write in the same cycle cannot
  // collide: apb carries one address per access
  function automatic logic [7:0] gated_wr(input logic [7:0] cur,
    input logic [7:0] d, input logic [7:0] m, input logic g);
    gated_wr = g ? d : ((d & ~m) | (cur & m));
  endfunction : gated_wr

  logic gate_fall, gate_rise;
  assign gate_fall = wr && paddr == efc_pkg::ADDR_EFC && gate
                     && !wbyte[efc_pkg::EFC_GATE];
  assign gate_rise = wr && paddr == efc_pkg::ADDR_EFC && !gate
                     && wbyte[efc_pkg::EFC_GATE];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ier_reg     <= efc_pkg::RST_ZERO;
      fcr_reg     <= efc_pkg::RST_ZERO;
      mcr_reg     <= efc_pkg::RST_ZERO;
      sav_ier_reg <= efc_pkg::RST_ZERO;
      sav_isr_reg <= efc_pkg::RST_ZERO;
      sav_fcr_reg <= efc_pkg::RST_ZERO;
      sav_mcr_reg <= efc_pkg::RST_ZERO;
    end
    else if (gate_fall)
    begin
      sav_ier_reg <= ier_reg & efc_pkg::MASK_IER;
      sav_isr_reg <= isr_reg & efc_pkg::MASK_ISR;
      sav_fcr_reg <= fcr_reg & efc_pkg::MASK_FCR;
      sav_mcr_reg <= mcr_reg & efc_pkg::MASK_MCR;
      ier_reg     <= ier_reg & ~efc_pkg::MASK_IER;
      fcr_reg     <= fcr_reg & ~efc_pkg::MASK_FCR;
      mcr_reg     <= mcr_reg & ~efc_pkg::MASK_MCR;
    end
    else if (gate_rise)
    begin
      ier_reg <= (ier_reg & ~efc_pkg::MASK_IER) | sav_ier_reg;
      fcr_reg <= (fcr_reg & ~efc_pkg::MASK_FCR) | sav_fcr_reg;
      mcr_reg <= (mcr_reg & ~efc_pkg::MASK_MCR) | sav_mcr_reg;
    end
    else if (wr)
    begin
      // enhanced bits locked while gate is 0
      if (paddr == efc_pkg::ADDR_IER)
        ier_reg <= gated_wr(ier_reg, wbyte, efc_pkg::MASK_IER, gate);
      if (paddr == efc_pkg::ADDR_FCR)
        fcr_reg <= gated_wr(fcr_reg, wbyte, efc_pkg::MASK_FCR, gate);
      if (paddr == efc_pkg::ADDR_MCR)
        mcr_reg <= gated_wr(mcr_reg, wbyte, efc_pkg::MASK_MCR, gate);
    end
  end

  // ------------------------------------------------------------
  // interrupt source: special flag, read of isr clears it
  // ------------------------------------------------------------
  // set wins over read-clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      isr_reg <= efc_pkg::RST_ISR;
    else if (gate_fall)
      isr_reg <= isr_reg & ~efc_pkg::MASK_ISR;
    else if (gate_rise)
      isr_reg <= (isr_reg & ~efc_pkg::MASK_ISR) | sav_isr_reg;
    else if (spec_hit && gate)
      isr_reg[efc_pkg::ISR_SPEC] <= 1'b1;
    else if (rd && paddr == efc_pkg::ADDR_ISR)
      isr_reg[efc_pkg::ISR_SPEC] <= 1'b0;
  end

  // ------------------------------------------------------------
  // receive character matching
  // ------------------------------------------------------------
  // whole-byte compare, bit 0 against lsb
  assign spec_hit = rx_valid && efc_reg[efc_pkg::EFC_SPEC]
                    && rx_char == pau2_reg;

  // select 11 needs first then second char in sequence
  always_comb
  begin
    on_hit    = 1'b0;
    off_hit   = 1'b0;
    on_first  = 1'b0;
    off_first = 1'b0;
    case (rx_sel)
      2'b10:
      begin
        on_hit  = rx_valid && rx_char == res1_reg;
        off_hit = rx_valid && rx_char == pau1_reg;
      end
      2'b01:
      begin
        on_hit  = rx_valid && rx_char == res2_reg;
        off_hit = rx_valid && rx_char == pau2_reg;
      end
      2'b11:
      begin
        on_first  = rx_valid && rx_char == res1_reg;
        off_first = rx_valid && rx_char == pau1_reg;
        on_hit    = rx_valid && on_half_reg && rx_char == res2_reg;
        off_hit   = rx_valid && off_half_reg && rx_char == pau2_reg;
      end
      default:
      begin
        on_hit  = 1'b0;
        off_hit = 1'b0;
      end
    endcase
  end

  // first half of a pair remembered until the next character
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      on_half_reg  <= 1'b0;
      off_half_reg <= 1'b0;
    end
    else if (rx_valid)
    begin
      on_half_reg  <= on_first;
      off_half_reg <= off_first;
    end
  end

  // control characters are not pushed as payload
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_push      <= 1'b0;
      rx_push_data <= 8'h00;
    end
    else
    begin
      rx_push      <= rx_valid && !(sw_flow && (on_hit || off_hit
                      || on_first || off_first));
      rx_push_data <= rx_char;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      halted_reg <= 1'b0;
    else if (!sw_flow)
      halted_reg <= 1'b0;
    else if (off_hit)
      halted_reg <= 1'b1;
    else if (on_hit)
      halted_reg <= 1'b0;
  end

  // ------------------------------------------------------------
  // transmit gating
  // ------------------------------------------------------------
  // cts high blocks new character starts
  assign tx_start_ok = tx_want && !halted_reg
                       && !(efc_reg[efc_pkg::EFC_CTS] && cts_in);

  // pair selection to transmitter; pause/resume on rts edges
  assign send_select = tx_sel;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev_full_reg <= 1'b0;
      send_pause    <= 1'b0;
      send_resume   <= 1'b0;
    end
    else
    begin
      prev_full_reg <= rts_hold_reg;
      send_pause    <= (tx_sel != 2'b00) && rts_hold_reg && !prev_full_reg;
      send_resume   <= (tx_sel != 2'b00) && !rts_hold_reg && prev_full_reg;
    end
  end

  // ------------------------------------------------------------
  // automatic rts
  // ------------------------------------------------------------
  // hysteresis between next level and trigger level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rts_hold_reg <= 1'b0;
    else if (!efc_reg[efc_pkg::EFC_RTS])
      rts_hold_reg <= 1'b0;
    else if (rx_fill >= next_lvl)
      rts_hold_reg <= 1'b1;
    else if (rx_fill < trig_lvl)
      rts_hold_reg <= 1'b0;
  end

  assign rx_irq = efc_reg[efc_pkg::EFC_RTS] && rx_fill >= trig_lvl;

  // software rts when automatic rts is off; rts reset level is 1
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rts_out <= 1'b1;
    else if (efc_reg[efc_pkg::EFC_RTS])
      rts_out <= rts_hold_reg;
    else
      rts_out <= ~mcr_reg[efc_pkg::MCR_RTS];
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // readable auto-rts bit shows live hardware flow state
  always_comb
  begin
    prdata = 32'h0000_0000;
    case (paddr)
      efc_pkg::ADDR_EFC:
      begin
        prdata[7:0] = efc_reg;
        prdata[efc_pkg::EFC_RTS] = efc_reg[efc_pkg::EFC_RTS] & rts_hold_reg;
      end
      efc_pkg::ADDR_RES1: prdata[7:0] = res1_reg;
      efc_pkg::ADDR_RES2: prdata[7:0] = res2_reg;
      efc_pkg::ADDR_PAU1: prdata[7:0] = pau1_reg;
      efc_pkg::ADDR_PAU2: prdata[7:0] = pau2_reg;
      efc_pkg::ADDR_IER:  prdata[7:0] = ier_reg;
      efc_pkg::ADDR_ISR:  prdata[7:0] = isr_reg;
      efc_pkg::ADDR_FCR:  prdata[7:0] = fcr_reg;
      efc_pkg::ADDR_MCR:  prdata[7:0] = mcr_reg;
      efc_pkg::ADDR_STAT: prdata[2:0] = {rx_irq, rts_hold_reg, halted_reg};
      efc_pkg::ADDR_TRIG: prdata[5:0] = trig_reg;
      default:            prdata = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_cts_block;
    @(posedge pclk) disable iff (!presetn)
    (efc_reg[efc_pkg::EFC_CTS] && cts_in) |-> !tx_start_ok;
  endproperty
  a_cts_block: assert property (p_cts_block)
    else $error("start allowed while cts high");

  property p_cts_resume;
    @(posedge pclk) disable iff (!presetn)
    (tx_want && !cts_in && !halted_reg) |-> tx_start_ok;
  endproperty
  a_cts_resume: assert property (p_cts_resume)
    else $error("start blocked with cts low");

  property p_rts_up;
    @(posedge pclk) disable iff (!presetn)
    (efc_reg[efc_pkg::EFC_RTS] && rx_fill >= next_lvl
     && $stable(efc_reg)) |-> ##2 rts_out;
  endproperty
  a_rts_up: assert property (p_rts_up)
    else $error("rts not raised at next level");

  property p_rts_down;
    @(posedge pclk) disable iff (!presetn)
    (efc_reg[efc_pkg::EFC_RTS] && rx_fill < trig_lvl
     && $stable(efc_reg)) |=> !rts_hold_reg;
  endproperty
  a_rts_down: assert property (p_rts_down)
    else $error("rts hold not released below trigger");

  property p_spec_flag;
    @(posedge pclk) disable iff (!presetn)
    (spec_hit && gate && !gate_fall) |=> isr_reg[efc_pkg::ISR_SPEC];
  endproperty
  a_spec_flag: assert property (p_spec_flag)
    else $error("special flag not set");

  property p_lock;
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == efc_pkg::ADDR_IER && !gate) |=>
      ((ier_reg & efc_pkg::MASK_IER) ==
       $past(ier_reg & efc_pkg::MASK_IER));
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked ier field changed");

  property p_gate_clear;
    @(posedge pclk) disable iff (!presetn)
    gate_fall |=> ((mcr_reg & efc_pkg::MASK_MCR) == 8'h00);
  endproperty
  a_gate_clear: assert property (p_gate_clear)
    else $error("mcr enhanced field not cleared");

  // halt flag up and no new start granted in the same cycle
  sequence s_halted;
    halted_reg ##0 !tx_start_ok;
  endsequence

  property p_pause_halt;
    @(posedge pclk) disable iff (!presetn)
    (off_hit && sw_flow) |=> s_halted;
  endproperty
  a_pause_halt: assert property (p_pause_halt)
    else $error("pause char did not halt transmit");
endmodule : efc_ctrl

// [verilog/efc_pkg.sv]
// package for the enhanced flow-control block
// assumes 8-bit characters and a 32-bit APB register bus
package efc_pkg;
  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_EFC   = 8'h00; // enhanced_feature_control
  localparam logic [7:0] ADDR_RES1  = 8'h04; // resume_char_first
  localparam logic [7:0] ADDR_RES2  = 8'h08; // resume_char_second
  localparam logic [7:0] ADDR_PAU1  = 8'h0C; // pause_char_first
  localparam logic [7:0] ADDR_PAU2  = 8'h10; // pause_char_second
  localparam logic [7:0] ADDR_IER   = 8'h14; // interrupt_enable_reg
  localparam logic [7:0] ADDR_ISR   = 8'h18; // interrupt_source_reg
  localparam logic [7:0] ADDR_FCR   = 8'h1C; // fifo_control_reg
  localparam logic [7:0] ADDR_MCR   = 8'h20; // modem_control_reg
  localparam logic [7:0] ADDR_STAT  = 8'h24; // flow status
  localparam logic [7:0] ADDR_TRIG  = 8'h28; // rx trigger level
  // ------------------------------------------------------------
  // enhanced_feature_control fields
  // ------------------------------------------------------------
  localparam int EFC_CTS   = 7;
  localparam int EFC_RTS   = 6;
  localparam int EFC_SPEC  = 5;
  localparam int EFC_GATE  = 4;
  localparam int EFC_TX_HI = 3;
  localparam int EFC_TX_LO = 2;
  localparam int EFC_RX_HI = 1;
  localparam int EFC_RX_LO = 0;
  localparam int ISR_SPEC  = 4;
  localparam int MCR_RTS   = 1;
  // gated enhanced field masks
  localparam logic [7:0] MASK_IER = 8'hF0;
  localparam logic [7:0] MASK_ISR = 8'h30;
  localparam logic [7:0] MASK_FCR = 8'h30;
  localparam logic [7:0] MASK_MCR = 8'hE0;
  // reset values
  localparam logic [7:0] RST_EFC  = 8'h00;
  localparam logic [7:0] RST_ISR  = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [5:0] RST_TRIG = 6'h08;
  localparam logic [5:0] TRIG_STEP = 6'h04; // next trigger level above
endpackage : efc_pkg
